// *** rtl/sbcscp_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcscp_buffer #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_clk,       // System clock
    input  wire logic             i_resetn,    // Async reset, active low
    input  wire logic             i_in_valid,  // Word offered
    output logic                  o_in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] i_in_data,   // Word in
    output logic                  o_out_valid, // Head word present
    input  wire logic             i_out_ready, // Consumer takes head
    output logic      [WIDTH-1:0] o_out_data   // Head word, registered
);
    logic [WIDTH-1:0] tail;
    logic             tail_valid;
    logic             push;
    logic             pop;

    // Room only while the tail slot is free
    assign o_in_ready = !tail_valid;
    assign push       = i_in_valid && !tail_valid;
    assign pop        = o_out_valid && i_out_ready;

    // Head and tail slots, head always the oldest word
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_out_data  <= '0;
            o_out_valid <= 1'b0;
            tail        <= '0;
            tail_valid  <= 1'b0;
        end else if (pop) begin
            if (tail_valid) begin
                o_out_data <= tail;
                tail_valid <= 1'b0;
            end else begin
                o_out_valid <= push;
                if (push) begin
                    o_out_data <= i_in_data;
                end
            end
        end else if (push) begin
            if (!o_out_valid) begin
                o_out_data  <= i_in_data;
                o_out_valid <= 1'b1;
            end else begin
                tail       <= i_in_data;
                tail_valid <= 1'b1;
            end
        end
    end
endmodule // sbcscp_buffer
`default_nettype wire

// *** rtl/sbcscp_pkg.sv ***
package sbcscp_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_W      = 16;
    localparam int WD_POS      = 15;  // Watchdog trigger bit, first in
    localparam int MODE_HI     = 14;
    localparam int MODE_LO     = 12;
    localparam int SEL_HI      = 11;
    localparam int SEL_LO      = 9;
    localparam int DATA_W      = 9;   // Payload below the select field
    localparam int FERR_POS    = 15;  // Frame error bit, first out
    localparam int HDR_BITS    = 7;   // Bits before the payload

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_INVALID = 3'h0;
    localparam logic [2:0]  MODE_READ    = 3'h7;
    localparam logic [2:0]  SEL_INT_LAST = 3'h2;   // Selects 0..2 are interrupt regs
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam logic [3:0]  CNT_RESET    = 4'h0;
    localparam logic [3:0]  CNT_HDR      = 4'h7;
    localparam logic [2:0]  SYNC_RESET   = 3'h7;   // Idle: deselected, clock high

    // Frame sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FRAME = 2'b01,
        ST_CHECK = 2'b10
    } sbcscp_state_type;

endpackage : sbcscp_pkg

// *** rtl/sbcscp_serial_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcscp_serial_port (
    input  wire logic                          i_clk,            // 10 MHz clock
    input  wire logic                          i_resetn,         // Async reset, low
    input  wire logic                          i_chip_select_n,  // Frame select pin
    input  wire logic                          i_sclk,           // Serial clock pin
    input  wire logic                          i_sdi,            // Serial data in pin
    output logic                               o_sdo,            // Serial data out
    output logic                               o_sdo_oe,         // Drive enable for sdo
    input  wire logic [sbcscp_pkg::WORD_W-1:0] i_status_word,    // Chip response word
    input  wire logic [7:0]                    i_allowed_modes,  // Permitted targets
    input  wire logic [sbcscp_pkg::DATA_W-1:0] i_reg_data,       // Selected reg content
    input  wire logic                          i_int_inhibit,    // Fail irq masked
    output logic      [2:0]                    o_reg_sel,        // Register to read
    output logic                               o_int_clear,      // Clear irq bits pulse
    output logic                               o_spi_fail,       // Sticky command fail
    output logic                               o_int_req,        // Fail irq pulse
    output logic                               o_frame_error,    // Last frame miscount
    output logic                               o_ctrl_valid,     // Control word ready
    input  wire logic                          i_ctrl_ready,     // Chip takes word
    output logic      [sbcscp_pkg::WORD_W-1:0] o_ctrl_word       // New control word
);
    import sbcscp_pkg::*;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic       csn_s;
    logic       sclk_s;
    logic       sdi_s;
    logic       csn_d;
    logic       sclk_d;

    // Pins pass four flops before use
    sbcscp_sync #(
        .WIDTH (3),
        .INIT  (SYNC_RESET)
    ) u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  ({i_chip_select_n, i_sclk, i_sdi}),
        .o_stable (pins_s)
    );

    assign csn_s  = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    // Previous values for edge finding
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            csn_d  <= 1'b1;
            sclk_d <= 1'b1;
        end else begin
            csn_d  <= csn_s;
            sclk_d <= sclk_s;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;

    // Clock edges only count inside a frame
    assign cs_fall   = csn_d && !csn_s;
    assign cs_rise   = !csn_d && csn_s;
    assign sclk_fall = !csn_s && sclk_d && !sclk_s;
    assign sclk_rise = !csn_s && !sclk_d && sclk_s;

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    sbcscp_state_type state;
    sbcscp_state_type next_state;

    // Idle until selected, frame until released, one cycle to judge
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cs_fall) begin
                    next_state = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (cs_rise) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    logic [WORD_W-1:0] in_sr;
    logic [3:0]        bit_cnt;
    logic              any_clk;

    // Shift in on falling edges; fresh start at each select
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            in_sr   <= WORD_RESET;
            bit_cnt <= CNT_RESET;
            any_clk <= 1'b0;
        end else if (cs_fall) begin
            in_sr   <= WORD_RESET;
            bit_cnt <= CNT_RESET;
            any_clk <= 1'b0;
        end else if (sclk_fall && state == ST_FRAME) begin
            in_sr   <= {in_sr[WORD_W-2:0], sdi_s};
            bit_cnt <= bit_cnt + 4'h1;
            any_clk <= 1'b1;
        end
    end

    // Field views of the received word
    logic [2:0] mode_select_field;
    logic [2:0] register_select_field;
    logic       count_ok;

    assign mode_select_field     = in_sr[MODE_HI:MODE_LO];
    assign register_select_field = in_sr[SEL_HI:SEL_LO];
    // Whole words only: a multiple of sixteen edges, at least one word
    assign count_ok = any_clk && (bit_cnt == CNT_RESET);

    // ------------------------------------------------------------
    // Read-only access within the frame
    // ------------------------------------------------------------
    logic hdr_seen;
    logic read_frame;
    logic load_data;

    // Header complete once seven bits are in; load_data is a one-cycle strobe
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hdr_seen   <= 1'b0;
            read_frame <= 1'b0;
            load_data  <= 1'b0;
            o_reg_sel  <= 3'h0;
        end else if (cs_fall) begin
            hdr_seen   <= 1'b0;
            read_frame <= 1'b0;
            load_data  <= 1'b0;
        end else if (!hdr_seen && any_clk && bit_cnt == CNT_HDR) begin
            hdr_seen <= 1'b1;
            // Mode and select sit in the low six bits while the header settles
            if (in_sr[MODE_HI-SEL_LO:MODE_LO-SEL_LO] == MODE_READ) begin
                read_frame <= 1'b1;
                load_data  <= 1'b1;
                o_reg_sel  <= in_sr[SEL_HI-SEL_LO:0];
            end
        end else begin
            load_data <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Command judgement at deselect
    // ------------------------------------------------------------
    logic judge;
    logic is_read;
    logic reject;
    logic buf_ready;

    assign judge   = (state == ST_CHECK);
    assign is_read = (mode_select_field == MODE_READ);

    // Wrong count, invalid mode, forbidden transition, no room
    always_comb begin
        reject = 1'b0;
        if (!count_ok) begin
            reject = 1'b1;
        end else if (mode_select_field == MODE_INVALID) begin
            reject = 1'b1;
        end else if (!is_read) begin
            if (!i_allowed_modes[mode_select_field]) begin
                reject = 1'b1;
            end else if (!buf_ready) begin
                reject = 1'b1;
            end
        end
    end

    logic push;
    // Accepted write commands become the control word; reads write nothing
    assign push = judge && !reject && !is_read;

    sbcscp_buffer #(
        .WIDTH (WORD_W)
    ) u_buffer (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (push),
        .o_in_ready  (buf_ready),
        .i_in_data   (in_sr),
        .o_out_valid (o_ctrl_valid),
        .i_out_ready (i_ctrl_ready),
        .o_out_data  (o_ctrl_word)
    );

    // ------------------------------------------------------------
    // Failure flags and interrupt
    // ------------------------------------------------------------
    logic fail_clear;
    logic repeat_next;

    // A good read of the failure register clears the fail bit
    assign fail_clear = o_int_clear && (o_reg_sel == SEL_INT_LAST);

    // Fail bit is sticky; a new rejection wins over a clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_spi_fail <= 1'b0;
        end else if (judge && reject) begin
            o_spi_fail <= 1'b1;
        end else if (fail_clear) begin
            o_spi_fail <= 1'b0;
        end
    end

    // One-cycle pulses from the judgement
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_int_req   <= 1'b0;
            o_int_clear <= 1'b0;
        end else begin
            o_int_req   <= judge && reject && !i_int_inhibit;
            o_int_clear <= judge && !reject && is_read && read_frame
                           && (o_reg_sel <= SEL_INT_LAST);
        end
    end

    // Remember miscount and rejection for the next frame
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_frame_error <= 1'b0;
            repeat_next   <= 1'b0;
        end else if (judge) begin
            o_frame_error <= !count_ok;
            repeat_next   <= reject;
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic [WORD_W-1:0] out_sr;
    logic [WORD_W-1:0] last_tx;
    logic [WORD_W-1:0] next_word;

    // Fresh status, or the former word again after a rejection
    always_comb begin
        if (repeat_next) begin
            next_word = last_tx;
        end else begin
            next_word = i_status_word;
        end
        next_word[FERR_POS] = o_frame_error;
    end

    // Load at select, shift after rising edges, patch in read data
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            out_sr  <= WORD_RESET;
            last_tx <= WORD_RESET;
        end else if (cs_fall) begin
            out_sr  <= next_word;
            last_tx <= next_word;
        end else if (sclk_rise && state == ST_FRAME) begin
            out_sr <= {out_sr[WORD_W-2:0], 1'b0};
        end else if (load_data) begin
            // Last header bit is on the pin; the payload is the next nine out
            out_sr[WORD_W-2 -: DATA_W] <= i_reg_data;
            last_tx[DATA_W-1:0]        <= i_reg_data;
        end
    end

    // Pin drive: only the own word; first bit straight from the load, no stale bit
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
        end else begin
            if (cs_fall) begin
                o_sdo <= next_word[WORD_W-1];
            end else begin
                o_sdo <= out_sr[WORD_W-1];
            end
            o_sdo_oe <= !csn_s;
        end
    end

endmodule // sbcscp_serial_port
`default_nettype wire

// *** rtl/sbcscp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcscp_sync #(
    parameter int             WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             i_clk,    // System clock
    input  wire logic             i_resetn, // Async reset, active low
    input  wire logic [WIDTH-1:0] i_async,  // Pins from outside the domain
    output logic      [WIDTH-1:0] o_stable  // Value once stages two and three agree
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Three flop chain; stage1 feeds stage2 only
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Per bit, accept a change only when the later stages agree
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_stable <= INIT;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    o_stable[i] <= stage3[i];
                end
            end
        end
    end
endmodule // sbcscp_sync
`default_nettype wire

// *** test/sbcscp_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcscp_master_model (
    output var logic o_chip_select_n, // Frame select to device
    output var logic o_sclk,          // Serial clock, idle high
    output var logic o_sdi,           // Serial data to device
    input  wire logic i_sdo           // Shared data line from device
);
    localparam int HALF = 400;

    // Idle link: deselected, clock high
    initial begin
        o_chip_select_n = 1'b1;
        o_sclk = 1'b1;
        o_sdi = 1'b0;
    end

    // One frame of nbits, MSB first; odd offset keeps edges off the system clock
    // The device answers several system cycles after a rise, so sdo is read at the next rise
    task automatic frame(input logic [15:0] word, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #37;
        o_chip_select_n = 1'b0;
        #(HALF);
        for (int i = 0; i < nbits; i++) begin
            o_sdi = word[15-i];
            #(HALF);
            o_sclk = 1'b0;
            #(HALF);
            rx = {rx[14:0], i_sdo};
            o_sclk = 1'b1;
        end
        #(HALF);
        o_chip_select_n = 1'b1;
        o_sdi = ~o_sdi; // Released line shows no stale value
        #(4*HALF);
    endtask

    // Clock and data activity while deselected
    task automatic noise();
        for (int i = 0; i < 4; i++) begin
            o_sdi = ~o_sdi;
            o_sclk = 1'b0;
            #(HALF);
            o_sclk = 1'b1;
            #(HALF);
        end
    endtask
endmodule // sbcscp_master_model
`default_nettype wire

// *** test/sbcscp_serial_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbcscp_serial_port_monitor (
    input wire logic                          i_clk,           // System clock
    input wire logic                          i_resetn,        // Async reset, low
    input wire logic                          i_chip_select_n, // Frame select pin
    input wire logic                          i_sclk,          // Serial clock pin
    input wire logic                          i_sdi,           // Serial data in
    input wire logic                          o_sdo,           // Serial data out
    input wire logic                          o_sdo_oe,        // Drive enable
    input wire logic [sbcscp_pkg::WORD_W-1:0] i_status_word,   // Response word
    input wire logic [7:0]                    i_allowed_modes, // Permitted targets
    input wire logic [sbcscp_pkg::DATA_W-1:0] i_reg_data,      // Register content
    input wire logic                          i_int_inhibit,   // Irq mask
    input wire logic [2:0]                    o_reg_sel,       // Register to read
    input wire logic                          o_int_clear,     // Clear pulse
    input wire logic                          o_spi_fail,      // Sticky fail
    input wire logic                          o_int_req,       // Fail irq pulse
    input wire logic                          o_frame_error,   // Miscount flag
    input wire logic                          o_ctrl_valid,    // Word ready
    input wire logic                          i_ctrl_ready,    // Word taken
    input wire logic [sbcscp_pkg::WORD_W-1:0] o_ctrl_word      // Control word
);
    import sbcscp_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Steps of a frame as seen at the pins
    sequence deselected_s; i_chip_select_n [*8]; endsequence
    sequence selected_s; !i_chip_select_n [*8]; endsequence
    sequence first_bit_s; $rose(o_sdo_oe); endsequence

    // Pin ownership, first bit, irq and buffer relations
    sdo_release_a: assert property (deselected_s |-> !o_sdo_oe)
        else $error("sdo still driven while deselected");
    sdo_drive_a: assert property (selected_s |-> o_sdo_oe)
        else $error("sdo not driven while selected");
    ferr_first_a: assert property (first_bit_s |-> o_sdo == o_frame_error)
        else $error("first bit differs from frame error flag");
    irq_mask_a: assert property (o_int_req |-> !i_int_inhibit && !$past(i_int_inhibit))
        else $error("irq raised while inhibited");
    irq_fail_a: assert property (o_int_req |-> ##[0:1] o_spi_fail)
        else $error("irq without fail bit");
    irq_pulse_a: assert property (o_int_req |=> !o_int_req)
        else $error("irq pulse longer than one cycle");
    judge_idle_a: assert property ((o_int_req || o_int_clear) |->
        i_chip_select_n && $past(i_chip_select_n, 3))
        else $error("frame judged before deselection");
    ctrl_hold_a: assert property (o_ctrl_valid && !i_ctrl_ready |=>
        o_ctrl_valid && $stable(o_ctrl_word))
        else $error("control word lost before taken");
    clear_sel_a: assert property (o_int_clear |-> o_reg_sel <= SEL_INT_LAST)
        else $error("clear pulse for non interrupt register");
endmodule // sbcscp_serial_port_monitor

bind sbcscp_serial_port sbcscp_serial_port_monitor u_mon (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_chip_select_n(i_chip_select_n),
    .i_sclk(i_sclk), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .i_status_word(i_status_word), .i_allowed_modes(i_allowed_modes),
    .i_reg_data(i_reg_data), .i_int_inhibit(i_int_inhibit), .o_reg_sel(o_reg_sel),
    .o_int_clear(o_int_clear), .o_spi_fail(o_spi_fail), .o_int_req(o_int_req),
    .o_frame_error(o_frame_error), .o_ctrl_valid(o_ctrl_valid),
    .i_ctrl_ready(i_ctrl_ready), .o_ctrl_word(o_ctrl_word));
`default_nettype wire

// *** test/tb_sbc_serial_control_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sbc_serial_control_port;
    import sbcscp_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [15:0] i_status_word = 16'h0000;
    logic [7:0]  i_allowed_modes = 8'h88;
    logic [8:0]  i_reg_data = 9'h1A5;
    logic        i_int_inhibit = 1'b0;
    logic        i_ctrl_ready = 1'b0;
    wire logic   cs_n, sclk, sdi, o_sdo, o_sdo_oe, o_int_clear, o_spi_fail;
    wire logic   o_int_req, o_frame_error, o_ctrl_valid;
    wire logic [2:0]  o_reg_sel;
    wire logic [15:0] o_ctrl_word;
    wire logic   sdo_line;
    logic [15:0] rx;
    int          miscompares = 0;
    int          total_checks = 0;
    int          n_irq = 0;
    int          n_clr = 0;

    // Clock and shared output line
    always #50 i_clk = ~i_clk;
    assign sdo_line = o_sdo_oe ? o_sdo : 1'bz;

    sbcscp_serial_port dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_chip_select_n(cs_n),
        .i_sclk(sclk), .i_sdi(sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
        .i_status_word(i_status_word), .i_allowed_modes(i_allowed_modes),
        .i_reg_data(i_reg_data), .i_int_inhibit(i_int_inhibit), .o_reg_sel(o_reg_sel),
        .o_int_clear(o_int_clear), .o_spi_fail(o_spi_fail), .o_int_req(o_int_req),
        .o_frame_error(o_frame_error), .o_ctrl_valid(o_ctrl_valid),
        .i_ctrl_ready(i_ctrl_ready), .o_ctrl_word(o_ctrl_word));
    sbcscp_master_model u_master (.o_chip_select_n(cs_n), .o_sclk(sclk), .o_sdi(sdi),
        .i_sdo(sdo_line));

    // Count irq and clear pulses
    always @(posedge i_clk) begin
        if (o_int_req === 1'b1) n_irq <= n_irq + 1;
        if (o_int_clear === 1'b1) n_clr <= n_clr + 1;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Status set at a falling edge, then one frame; full frames compare the response
    task automatic send(input logic [15:0] st, input logic [15:0] w, input int nb,
                        input logic [15:0] exp_rx);
        i_status_word = st;
        u_master.frame(w, nb, rx);
        if (nb == 16) check(rx, exp_rx);
        @(negedge i_clk);
    endtask

    // Wait for the head word, compare it and take it for one cycle
    task automatic take(input logic [15:0] exp);
        int n;
        n = 0;
        while (o_ctrl_valid !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        check(o_ctrl_word, exp);
        i_ctrl_ready = 1'b1;
        @(negedge i_clk);
        i_ctrl_ready = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #2000000;
        miscompares++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (4) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (8) @(negedge i_clk);
        send(16'h1234, 16'hB805, 16, 16'h1234);
        check(o_ctrl_word, 16'hB805);
        send(16'h2345, 16'h3A11, 16, 16'h2345);
        check(16'(n_irq), 16'h0000);
        $display("test write frames done");
        send(16'h3456, 16'hB0FF, 16, 16'h3456);
        check({15'h0000, o_spi_fail}, 16'h0001);
        check(16'(n_irq), 16'h0001);
        send(16'h4567, 16'h0123, 16, 16'h3456);
        check(16'(n_irq), 16'h0002);
        take(16'hB805);
        take(16'h3A11);
        check({15'h0000, o_ctrl_valid}, 16'h0000);
        $display("test full buffer and invalid mode done");
        i_int_inhibit = 1'b1;
        send(16'h4567, 16'hD000, 16, 16'h3456);
        check(16'(n_irq), 16'h0002);
        check({15'h0000, o_ctrl_valid}, 16'h0000);
        i_int_inhibit = 1'b0;
        $display("test disallowed mode done");
        send(16'h4567, 16'hB001, 16, 16'h3456);
        take(16'hB001);
        send(16'h5678, 16'hF400, 16, 16'h57A5);
        check(16'(n_clr), 16'h0001);
        check({13'h0000, o_reg_sel}, 16'h0002);
        check({14'h0000, o_spi_fail, o_ctrl_valid}, 16'h0000);
        $display("test read frame done");
        send(16'h5678, 16'hB002, 15, 16'h0000);
        check({14'h0000, o_frame_error, o_ctrl_valid}, 16'h0002);
        check(16'(n_irq), 16'h0003);
        send(16'h5678, 16'hB003, 16, 16'hD678);
        check({15'h0000, o_frame_error}, 16'h0000);
        take(16'hB003);
        $display("test clock count done");
        u_master.noise();
        repeat (20) @(negedge i_clk);
        check({15'h0000, o_ctrl_valid}, 16'h0000);
        check(16'(n_irq), 16'h0003);
        $display("test deselected activity done");
        tally_and_finish();
    end
endmodule // tb_sbc_serial_control_port
`default_nettype wire
